// File: hdl/fbrw_pkg.sv
// fbrw_pkg: register map, field positions and encodings of the framebuffer read/write unit
// assumes a 32-bit AHB-Lite register bus, one aligned word per register
package fbrw_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_SOFT_MASK = 10'h104;
    localparam logic [9:0] IDX_CONST_PIX = 10'h106;
    localparam logic [9:0] IDX_LOGIC_OP = 10'h108;
    localparam logic [9:0] IDX_READ_CTRL = 10'h150;
    localparam logic [9:0] IDX_SRC_DELTA = 10'h151;
    localparam logic [9:0] IDX_MBUF_DELTA = 10'h152;
    localparam logic [9:0] IDX_FMT_DATA = 10'h154;
    localparam logic [9:0] IDX_SRC_DATA = 10'h155;
    localparam logic [9:0] IDX_WIN_BASE = 10'h156;
    localparam logic [9:0] IDX_WRITE_CTRL = 10'h157;
    localparam logic [9:0] IDX_HARD_MASK = 10'h158;
    localparam logic [9:0] IDX_BLOCK_COLOR = 10'h159;
    localparam logic [9:0] IDX_PIX_SIZE = 10'h15A;
    localparam logic [9:0] IDX_STATUS = 10'h15B;
    localparam logic [9:0] IDX_CULL_CTRL = 10'h180;
    // read control fields
    localparam int RC_PP0_LSB = 0;
    localparam int RC_PP1_LSB = 3;
    localparam int RC_PP2_LSB = 6;
    localparam int RC_SRC_EN = 9;
    localparam int RC_DST_EN = 10;
    localparam int RC_DATA_TYPE = 15;
    localparam int RC_ORIGIN = 16;
    localparam int RC_PATCH_EN = 18;
    localparam int RC_PACKED = 19;
    localparam int RC_SHIFT_LSB = 20;
    localparam int RC_PMODE_LSB = 25;
    // write control, logic op and cull control fields
    localparam int WC_WR_EN = 0;
    localparam int WC_UPLOAD_LSB = 3;
    localparam logic [1:0] UPLOAD_NONE = 2'h0;
    localparam logic [1:0] UPLOAD_COLOR = 2'h2;
    localparam int LO_CONST_SEL = 5;
    localparam int CF_DEPTH_TAG = 4;
    localparam int CF_DEPTH_DATA = 5;
    localparam int CF_STENCIL_TAG = 6;
    localparam logic [31:0] CF_MASK = 32'h0000_0070;
    localparam logic [31:0] WIN_MASK = 32'h00FF_FFFF;
    // patch styles and pixel sizes
    typedef enum logic [1:0] {
        PATCH_FULL = 2'b00,
        PATCH_SUB = 2'b01,
        PATCH_SUB_PACK = 2'b10
    } fbrw_patch_e;
    typedef enum logic [1:0] {
        PIX_8 = 2'b00,
        PIX_16 = 2'b01,
        PIX_32 = 2'b10
    } fbrw_pix_e;
    // output word kinds
    localparam logic [1:0] KIND_DEPTH = 2'h0;
    localparam logic [1:0] KIND_STENCIL = 2'h1;
    localparam logic [1:0] KIND_COLOR = 2'h2;
    localparam logic [15:0] TAG_COLOR = 16'h0153;
endpackage

// File: hdl/fbrw_mask_merge.sv
// fbrw_mask_merge: bitwise merge of new and old framebuffer words under a mask
// assumes mask bits of one enable the new data
`timescale 1ns/1ps
`default_nettype none
module fbrw_mask_merge #(
    parameter int WIDTH = 32
) (
    // operands
    input wire logic [WIDTH-1:0] newData,
    input wire logic [WIDTH-1:0] oldData,
    input wire logic [WIDTH-1:0] mask,
    // result
    output logic [WIDTH-1:0] merged
);
    // mask bits of zero keep the old value
    assign merged = (newData & mask) | (oldData & ~mask);
endmodule // fbrw_mask_merge
`default_nettype wire

// File: hdl/fbrw_unit.sv
// fbrw_unit: framebuffer read/write stage with AHB-Lite registers
// assumes a single-port framebuffer memory answering each read after any delay (fbRdValid)
`timescale 1ns/1ps
`default_nettype none
module fbrw_unit
    import fbrw_pkg::*;
#(
    parameter int AW = 24
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // fragment stream in
    input wire logic fragValid,
    input wire logic [AW-1:0] fragAddr,
    input wire logic [31:0] fragColor,
    input wire logic fragBlock,
    input wire logic [1:0] fragKind,
    output logic fragReady,
    // framebuffer memory
    output logic fbRdReq,
    output logic [AW-1:0] fbRdAddr,
    output logic [1:0] fbRdSize,
    output logic fbRdPacked,
    input wire logic fbRdValid,
    input wire logic [31:0] fbRdData,
    output logic fbWrReq,
    output logic [AW-1:0] fbWrAddr,
    output logic [31:0] fbWrData,
    output logic [31:0] fbWrMask,
    output logic fbBlockWr,
    output logic fbPatchEn,
    output logic [1:0] fbPatchMode,
    output logic fbOriginBottom,
    output logic [8:0] fbPartProd,
    // host output FIFO
    output logic outValid,
    output logic [31:0] outData,
    input wire logic outReady
);
    import fbrw_pkg::*;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD_SRC = 3'b001,
        ST_RD_DST = 3'b010,
        ST_WRITE = 3'b011,
        ST_TAG = 3'b100,
        ST_DATA = 3'b101
    } fbrw_state_e;

    logic [31:0] softMask_reg, constPix_reg, logicOp_reg, readCtrl_reg, srcDelta_reg;
    logic [31:0] mbufDelta_reg, fmtData_reg, srcData_reg, winBase_reg, writeCtrl_reg;
    logic [31:0] hardMask_reg, blockColor_reg, pixSize_reg, cullCtrl_reg;
    logic wrPend_reg;
    logic [9:0] wrIdx_reg;
    fbrw_state_e state_reg;
    logic [AW-1:0] addr_reg;
    logic [31:0] color_reg, srcPix_reg, dstPix_reg;
    logic block_reg;
    logic [1:0] kind_reg;
    logic passTag_reg;
    logic [9:0] rdIdx;
    logic [31:0] rdWord, srcAligned, newPixel, mergedPixel;
    logic [AW-1:0] dstAddr, srcAddr;
    logic srcEn, dstEn, uploadMode, tagPass, dataPass;
    logic [5:0] shiftBits;
    logic [2:0] shiftMag;

    // bus decode: word index from byte address
    assign rdIdx = haddr[11:2];

    // read multiplexer of register words
    always_comb begin
        unique case (rdIdx)
            IDX_SOFT_MASK: rdWord = softMask_reg;
            IDX_CONST_PIX: rdWord = constPix_reg;
            IDX_LOGIC_OP: rdWord = logicOp_reg;
            IDX_READ_CTRL: rdWord = readCtrl_reg;
            IDX_SRC_DELTA: rdWord = srcDelta_reg;
            IDX_MBUF_DELTA: rdWord = mbufDelta_reg;
            IDX_WIN_BASE: rdWord = winBase_reg & WIN_MASK;
            IDX_WRITE_CTRL: rdWord = writeCtrl_reg;
            IDX_HARD_MASK: rdWord = hardMask_reg;
            IDX_BLOCK_COLOR: rdWord = blockColor_reg;
            IDX_PIX_SIZE: rdWord = pixSize_reg;
            IDX_STATUS: rdWord = {29'h0, state_reg};
            IDX_CULL_CTRL: rdWord = cullCtrl_reg;
            default: rdWord = 32'h0000_0000;
        endcase
    end

    // address phase capture; zero wait, always OKAY
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPend_reg <= 1'b0;
            wrIdx_reg <= 10'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_reg <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                wrIdx_reg <= rdIdx;
                if (!hwrite) begin
                    hrdata <= rdWord;
                end
            end
        end
    end

    // register writes in the data phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            softMask_reg <= 32'hFFFF_FFFF;
            constPix_reg <= 32'h0000_0000;
            logicOp_reg <= 32'h0000_0000;
            readCtrl_reg <= 32'h0000_0000;
            srcDelta_reg <= 32'h0000_0000;
            mbufDelta_reg <= 32'h0000_0000;
            fmtData_reg <= 32'h0000_0000;
            srcData_reg <= 32'h0000_0000;
            winBase_reg <= 32'h0000_0000;
            writeCtrl_reg <= 32'h0000_0000;
            hardMask_reg <= 32'hFFFF_FFFF;
            blockColor_reg <= 32'h0000_0000;
            pixSize_reg <= 32'h0000_0000;
            cullCtrl_reg <= 32'h0000_0000;
        end else if (wrPend_reg) begin
            unique case (wrIdx_reg)
                IDX_SOFT_MASK: softMask_reg <= hwdata;
                IDX_CONST_PIX: constPix_reg <= hwdata;
                IDX_LOGIC_OP: logicOp_reg <= hwdata;
                IDX_READ_CTRL: readCtrl_reg <= hwdata;
                IDX_SRC_DELTA: srcDelta_reg <= hwdata;
                IDX_MBUF_DELTA: mbufDelta_reg <= hwdata;
                IDX_FMT_DATA: fmtData_reg <= hwdata;
                IDX_SRC_DATA: srcData_reg <= hwdata;
                IDX_WIN_BASE: winBase_reg <= hwdata & WIN_MASK;
                IDX_WRITE_CTRL: writeCtrl_reg <= hwdata;
                IDX_HARD_MASK: hardMask_reg <= hwdata;
                IDX_BLOCK_COLOR: blockColor_reg <= hwdata;
                IDX_PIX_SIZE: pixSize_reg <= {30'h0, hwdata[1:0]};
                IDX_CULL_CTRL: cullCtrl_reg <= hwdata & CF_MASK;
                default: ;
            endcase
        end
    end

    // control decode
    assign srcEn = readCtrl_reg[RC_SRC_EN];
    assign dstEn = readCtrl_reg[RC_DST_EN];
    assign uploadMode = readCtrl_reg[RC_DATA_TYPE] &&
        (writeCtrl_reg[WC_UPLOAD_LSB +: 2] == UPLOAD_COLOR);
    assign dstAddr = winBase_reg[AW-1:0] + addr_reg;
    assign srcAddr = dstAddr - srcDelta_reg[AW-1:0];

    // signed pixel shift aligning source with destination
    always_comb begin
        shiftMag = readCtrl_reg[RC_SHIFT_LSB + 2] ?
            3'(-readCtrl_reg[RC_SHIFT_LSB +: 3]) : readCtrl_reg[RC_SHIFT_LSB +: 3];
        unique case (pixSize_reg[1:0])
            PIX_8: shiftBits = {shiftMag, 3'h0};
            PIX_16: shiftBits = {shiftMag[1:0], 4'h0};
            default: shiftBits = 6'h00;
        endcase
        if (shiftBits[5]) begin
            srcAligned = srcPix_reg;
        end else if (readCtrl_reg[RC_SHIFT_LSB + 2]) begin
            srcAligned = srcPix_reg >> shiftBits[4:0];
        end else begin
            srcAligned = srcPix_reg << shiftBits[4:0];
        end
    end

    // data to write: constant, block, shifted source or fragment colour
    always_comb begin
        if (logicOp_reg[LO_CONST_SEL]) begin
            newPixel = constPix_reg;
        end else if (block_reg) begin
            newPixel = blockColor_reg;
        end else if (srcEn && readCtrl_reg[RC_SHIFT_LSB +: 3] != 3'h0) begin
            newPixel = srcAligned;
        end else begin
            newPixel = color_reg;
        end
    end

    // software mask preserves old destination bits, or old source bits without a destination read
    fbrw_mask_merge #(
        .WIDTH(32)
    ) fbrw_mask_merge_i (
        .newData(newPixel),
        .oldData(dstEn ? dstPix_reg : srcPix_reg),
        .mask(softMask_reg),
        .merged(mergedPixel)
    );

    // cull filter for the current word kind
    always_comb begin
        unique case (kind_reg)
            KIND_DEPTH: begin
                tagPass = cullCtrl_reg[CF_DEPTH_TAG];
                dataPass = cullCtrl_reg[CF_DEPTH_DATA];
            end
            KIND_STENCIL: begin
                tagPass = cullCtrl_reg[CF_STENCIL_TAG];
                dataPass = 1'b1;
            end
            default: begin
                tagPass = 1'b1;
                dataPass = 1'b1;
            end
        endcase
    end

    // pixel sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            addr_reg <= '0;
            color_reg <= 32'h0000_0000;
            block_reg <= 1'b0;
            kind_reg <= KIND_COLOR;
            srcPix_reg <= 32'h0000_0000;
            dstPix_reg <= 32'h0000_0000;
            passTag_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (fragValid) begin
                        addr_reg <= fragAddr;
                        color_reg <= fragColor;
                        block_reg <= fragBlock;
                        kind_reg <= fragKind;
                        if (srcEn) begin
                            state_reg <= ST_RD_SRC;
                        end else if (dstEn) begin
                            state_reg <= ST_RD_DST;
                        end else begin
                            state_reg <= ST_WRITE;
                        end
                    end
                end
                ST_RD_SRC: begin
                    if (fbRdValid) begin
                        srcPix_reg <= fbRdData;
                        state_reg <= dstEn ? ST_RD_DST : ST_WRITE;
                    end
                end
                ST_RD_DST: begin
                    if (fbRdValid) begin
                        dstPix_reg <= fbRdData;
                        state_reg <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (uploadMode) begin
                        passTag_reg <= dataPass;
                        state_reg <= tagPass ? ST_TAG : (dataPass ? ST_DATA : ST_IDLE);
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_TAG: begin
                    if (outReady) begin
                        state_reg <= passTag_reg ? ST_DATA : ST_IDLE;
                    end
                end
                ST_DATA: begin
                    if (outReady) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // framebuffer port outputs, registered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fbRdReq <= 1'b0;
            fbRdAddr <= '0;
            fbRdSize <= 2'h0;
            fbRdPacked <= 1'b0;
            fbWrReq <= 1'b0;
            fbWrAddr <= '0;
            fbWrData <= 32'h0000_0000;
            fbWrMask <= 32'h0000_0000;
            fbBlockWr <= 1'b0;
            fbPatchEn <= 1'b0;
            fbPatchMode <= 2'h0;
            fbOriginBottom <= 1'b0;
            fbPartProd <= 9'h000;
            fragReady <= 1'b0;
        end else begin
            fbRdReq <= (state_reg == ST_RD_SRC || state_reg == ST_RD_DST) && !fbRdValid;
            fbRdAddr <= (state_reg == ST_RD_SRC) ? srcAddr : dstAddr;
            fbRdSize <= pixSize_reg[1:0];
            fbRdPacked <= readCtrl_reg[RC_PACKED];
            fbPatchEn <= readCtrl_reg[RC_PATCH_EN];
            fbPatchMode <= readCtrl_reg[RC_PMODE_LSB +: 2];
            fbOriginBottom <= readCtrl_reg[RC_ORIGIN];
            fbPartProd <= readCtrl_reg[RC_PP0_LSB +: 9];
            fbWrReq <= (state_reg == ST_WRITE) && writeCtrl_reg[WC_WR_EN] && !uploadMode;
            fbWrAddr <= dstAddr;
            fbWrData <= mergedPixel;
            fbWrMask <= hardMask_reg;
            fbBlockWr <= block_reg;
            fragReady <= (state_reg == ST_IDLE) && !fragReady && fragValid;
        end
    end

    // output FIFO words: tag first, then data, each sent only if its cull filter passes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outValid <= 1'b0;
            outData <= 32'h0000_0000;
        end else if (outValid && !outReady) begin
            outValid <= 1'b1;
        end else if (state_reg == ST_WRITE && uploadMode) begin
            outValid <= tagPass || dataPass;
            outData <= tagPass ? {16'h0000, TAG_COLOR} : mergedPixel;
        end else if (state_reg == ST_TAG && outReady && passTag_reg) begin
            outValid <= 1'b1;
            outData <= mergedPixel;
        end else begin
            outValid <= 1'b0;
        end
    end
endmodule // fbrw_unit
`default_nettype wire

// File: dv/fbrw_unit_chk.sv
// fbrw_unit_chk: port-level checks of the framebuffer read/write unit
// assumes bind onto fbrw_unit, one clock domain, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module fbrw_unit_chk
    import fbrw_pkg::*;
#(
    parameter int AW = 24
) (
    // clock, reset, bus answer
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hreadyout,
    input wire logic hresp,
    // fragment and memory side
    input wire logic fragReady,
    input wire logic fbRdReq,
    input wire logic [AW-1:0] fbRdAddr,
    input wire logic [1:0] fbRdSize,
    input wire logic fbRdValid,
    input wire logic fbWrReq,
    // output fifo
    input wire logic outValid,
    input wire logic [31:0] outData,
    input wire logic outReady
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic wordOdd;
    // tag or data position of the next output word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wordOdd <= 1'b0;
        end else if (outValid && outReady) begin
            wordOdd <= !wordOdd;
        end
    end
    // zero-wait okay answers, pulses, holds and ordering
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_FRAG_PULSE: assert property (fragReady |=> !fragReady)
        else $error("fragment accept longer than one cycle");
    AST_WR_PULSE: assert property (fbWrReq |=> !fbWrReq)
        else $error("write request longer than one cycle");
    AST_WR_NO_RD: assert property (fbWrReq |-> !fbRdReq)
        else $error("write while a read is awaited");
    AST_RD_HOLD: assert property (fbRdReq && !fbRdValid |=> fbRdReq && $stable(fbRdAddr))
        else $error("read request dropped or moved before answer");
    AST_RD_SIZE: assert property (fbRdReq |-> fbRdSize != 2'h3)
        else $error("read size code out of range");
    AST_OUT_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outData))
        else $error("output word not held while stalled");
    AST_TAG_FIRST: assert property (outValid && !wordOdd |-> outData[15:0] == TAG_COLOR)
        else $error("first output word is not the tag");
    AST_UPLOAD_NO_WR: assert property (outValid |-> !fbWrReq)
        else $error("framebuffer write during upload");
    // main scenarios seen
    COV_WRITE: cover property (fbWrReq);
    COV_READ: cover property (fbRdReq && fbRdValid);
    COV_PAIR: cover property (outValid && outReady && wordOdd);
endmodule // fbrw_unit_chk
bind fbrw_unit fbrw_unit_chk #(.AW(AW)) fbrw_unit_chk_i (.clk_sys(clk_sys), .rst(rst),
    .hreadyout(hreadyout), .hresp(hresp), .fragReady(fragReady), .fbRdReq(fbRdReq),
    .fbRdAddr(fbRdAddr), .fbRdSize(fbRdSize), .fbRdValid(fbRdValid), .fbWrReq(fbWrReq),
    .outValid(outValid), .outData(outData), .outReady(outReady));
`default_nettype wire

// File: dv/fbrw_mem_model.sv
// fbrw_mem_model: framebuffer memory read port and host output fifo sink
// assumes fbRdReq stays high until answered; slow adds delay and stalls
`timescale 1ns/1ps
`default_nettype none
module fbrw_mem_model #(
    parameter int AW = 24
) (
    // clock, reset, pacing
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    // read port
    input wire logic fbRdReq,
    input wire logic [AW-1:0] fbRdAddr,
    output logic fbRdValid,
    output logic [31:0] fbRdData,
    // output fifo sink
    output logic outReady
);
    logic [2:0] waitCnt;
    logic [1:0] tick;
    // one answer per awaited read; data churns between answers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fbRdValid <= 1'b0;
            fbRdData <= 32'hA5C3_5A3C;
            waitCnt <= 3'h0;
        end else begin
            fbRdValid <= 1'b0;
            fbRdData <= ~fbRdData;
            if (fbRdReq && !fbRdValid) begin
                if (waitCnt == (slow ? 3'h3 : 3'h0)) begin
                    fbRdValid <= 1'b1;
                    fbRdData <= 32'(fbRdAddr) ^ 32'h5A00_0000;
                    waitCnt <= 3'h0;
                end else begin
                    waitCnt <= waitCnt + 3'h1;
                end
            end
        end
    end
    // fifo accepts one cycle in four when slow
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick <= 2'h0;
            outReady <= 1'b0;
        end else begin
            tick <= tick + 2'h1;
            outReady <= !slow || tick == 2'h3;
        end
    end
endmodule // fbrw_mem_model
`default_nettype wire

// File: dv/fbrw_unit_bench.sv
// fbrw_unit_bench: self-checking bench of the framebuffer read/write unit
// assumes fbrw_mem_model on the memory side; host registers over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t: mismatch", $time); end end
module fbrw_unit_bench;
    import fbrw_pkg::*;
    logic clk_sys, rst, hsel, hwrite, hreadyout, hresp, fragValid, fragBlock, fragReady;
    logic [31:0] haddr, hwdata, hrdata, fragColor, fbRdData, fbWrData, fbWrMask, outData;
    logic [2:0] hsize;
    logic [1:0] htrans, fragKind, fbRdSize, fbPatchMode, rdSz;
    logic [23:0] fragAddr, fbRdAddr, fbWrAddr, wA;
    logic [23:0] rdA [4];
    logic [31:0] oD [2];
    logic [31:0] rv, wD, wM;
    logic [8:0] fbPartProd;
    logic fbRdReq, fbRdPacked, fbRdValid, fbWrReq, fbBlockWr, fbPatchEn, fbOriginBottom;
    logic outValid, outReady, memSlow, rdPk, blkSeen;
    int bad_count, total_checks, rdN, wrN, oN, frN;
    logic [9:0] rwIdx [6] = '{IDX_SOFT_MASK, IDX_CONST_PIX, IDX_SRC_DELTA, IDX_MBUF_DELTA,
        IDX_HARD_MASK, IDX_BLOCK_COLOR};
    // design and memory side
    fbrw_unit fbrw_unit_i (.hready(hreadyout), .*);
    fbrw_mem_model fbrw_mem_model_i (.clk_sys(clk_sys), .rst(rst), .slow(memSlow),
        .fbRdReq(fbRdReq), .fbRdAddr(fbRdAddr), .fbRdValid(fbRdValid), .fbRdData(fbRdData),
        .outReady(outReady));
    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // wait for an edge with hready high, bounded
    task automatic wait_ready();
        for (int n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (hreadyout === 1'b1) return;
        end
        bad_count++;
        complete_run();
    endtask
    // one single-word transfer; read data lands in rv
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rv = hrdata;
    endtask
    // offer one fragment and log reads, writes and output words
    task automatic run_frag(input logic [23:0] a, input logic [31:0] c, input logic blk,
        input logic ex, input int bound);
        {rdN, wrN, oN, frN} = '0;
        fragValid <= 1'b1;
        fragAddr <= a;
        fragColor <= c;
        fragBlock <= blk;
        for (int n = 0; n < bound && wrN == 0 && oN < 2; n++) begin
            @(posedge clk_sys);
            if (fragReady === 1'b1) begin
                fragValid <= 1'b0;
                frN++;
            end
            if (fbRdValid === 1'b1 && rdN < 4) begin
                rdA[rdN] = fbRdAddr;
                rdSz = fbRdSize;
                rdPk = fbRdPacked;
                rdN++;
            end
            if (fbWrReq === 1'b1) begin
                {wA, wD, wM, blkSeen} = {fbWrAddr, fbWrData, fbWrMask, fbBlockWr};
                wrN++;
            end
            if (outValid === 1'b1 && outReady === 1'b1 && oN < 2) begin
                oD[oN] = outData;
                oN++;
            end
        end
        if (frN == 0) fragValid <= 1'b0;
        `CHK(frN, 1)
        if (ex && wrN == 0 && oN < 2) begin
            bad_count++;
            complete_run();
        end
    endtask
    // register access kinds, reserved bits and unmapped place
    task automatic test_regs();
        bus(0, IDX_HARD_MASK, 0);
        `CHK(rv, 32'hFFFF_FFFF)
        for (int i = 0; i < 6; i++) begin
            bus(1, rwIdx[i], 32'hC3A5_0F00 + i);
            bus(0, rwIdx[i], 0);
            `CHK(rv, 32'hC3A5_0F00 + i)
        end
        bus(1, IDX_WIN_BASE, 32'hFFFF_FFFF);
        bus(0, IDX_WIN_BASE, 0);
        `CHK(rv, 32'h00FF_FFFF)
        bus(1, IDX_CULL_CTRL, 32'hFFFF_FFFF);
        bus(0, IDX_CULL_CTRL, 0);
        `CHK(rv, 32'h0000_0070)
        bus(1, IDX_FMT_DATA, 32'h1234_5678);
        bus(0, IDX_FMT_DATA, 0);
        `CHK(rv, 32'h0)
        bus(0, 10'h3FF, 0);
        `CHK(rv, 32'h0)
    endtask
    // masked, constant, block and disabled writes
    task automatic test_write();
        bus(1, IDX_READ_CTRL, 0);
        bus(1, IDX_SOFT_MASK, 32'hFFFF_FFFF);
        bus(1, IDX_HARD_MASK, 32'h00FF_00FF);
        bus(1, IDX_WIN_BASE, 32'h0001_0000);
        bus(1, IDX_WRITE_CTRL, 1);
        bus(1, IDX_LOGIC_OP, 0);
        run_frag(24'h000123, 32'h1234_5678, 0, 1, 40);
        `CHK(wD, 32'h1234_5678)
        `CHK(wM, 32'h00FF_00FF)
        `CHK(wA, 24'h010123)
        `CHK(rdN, 0)
        bus(1, IDX_CONST_PIX, 32'h3C3C_3C3C);
        bus(1, IDX_LOGIC_OP, 32'h20);
        run_frag(24'h000124, 32'h1111_1111, 0, 1, 40);
        `CHK(wD, 32'h3C3C_3C3C)
        bus(1, IDX_LOGIC_OP, 0);
        bus(1, IDX_BLOCK_COLOR, 32'h7E7E_7E7E);
        run_frag(24'h000140, 32'h2222_2222, 1, 1, 40);
        `CHK(blkSeen, 1'b1)
        `CHK(wD, 32'h7E7E_7E7E)
        bus(1, IDX_WRITE_CTRL, 0);
        run_frag(24'h000125, 32'h3333_3333, 0, 0, 30);
        `CHK(wrN, 0)
    endtask
    // source and destination fetches with a slow memory
    task automatic test_read();
        bus(1, IDX_WRITE_CTRL, 1);
        bus(1, IDX_SOFT_MASK, 32'h0000_FFFF);
        bus(1, IDX_SRC_DELTA, 32'h40);
        bus(1, IDX_PIX_SIZE, 1);
        bus(1, IDX_READ_CTRL, 32'h045D_07A5);
        bus(0, IDX_READ_CTRL, 0);
        `CHK(rv, 32'h045D_07A5)
        memSlow <= 1'b1;
        run_frag(24'h000200, 32'h4444_4444, 0, 1, 60);
        `CHK(rdN, 2)
        `CHK(rdA[1] - rdA[0], 24'h40)
        `CHK(wA, rdA[1])
        `CHK({rdSz, rdPk}, 3'b011)
        `CHK({fbPatchEn, fbPatchMode}, {1'b1, PATCH_SUB_PACK})
        `CHK(fbOriginBottom, 1'b1)
        `CHK(fbPartProd, 9'h1A5)
        bus(1, IDX_PIX_SIZE, 0);
        bus(1, IDX_SOFT_MASK, 32'hFFFF_FFFF);
        bus(1, IDX_READ_CTRL, 32'h0000_0400);
        run_frag(24'h000201, 32'h5555_5555, 0, 1, 60);
        `CHK(rdN, 1)
        `CHK({rdSz, rdPk}, 3'b000)
        `CHK(fbPatchEn, 1'b0)
        bus(1, IDX_READ_CTRL, 32'h0010_0200);
        run_frag(24'h000202, 32'h0, 0, 1, 60);
        `CHK(wD, (32'(rdA[0]) ^ 32'h5A00_0000) << 8)
    endtask
    // colour upload through a stalling output fifo
    task automatic test_upload();
        bus(1, IDX_READ_CTRL, 32'h0000_8400);
        bus(1, IDX_WRITE_CTRL, 32'h11);
        bus(1, IDX_CULL_CTRL, 32'h70);
        bus(1, IDX_PIX_SIZE, 2);
        run_frag(24'h000300, 32'h6666_6666, 0, 1, 80);
        `CHK(oN, 2)
        `CHK(oD[0][15:0], TAG_COLOR)
        `CHK(oD[1], 32'h6666_6666)
        `CHK(wrN, 0)
        `CHK(rdSz, 2'h2)
        bus(1, IDX_CULL_CTRL, 32'h0);
        fragKind <= KIND_DEPTH;
        run_frag(24'h000301, 32'h7777_7777, 0, 0, 40);
        `CHK(oN, 0)
    endtask
    // reset, then the scenarios in turn
    initial begin
        {rst, memSlow} = 2'b10;
        {hsel, hwrite, fragValid, fragBlock} = '0;
        {haddr, hwdata, fragColor, fragAddr} = '0;
        {hsize, htrans, fragKind} = {3'h2, 2'h0, KIND_COLOR};
        {bad_count, total_checks} = '0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        test_regs();
        test_write();
        test_read();
        test_upload();
        complete_run();
    end
endmodule // fbrw_unit_bench
`default_nettype wire
